// ==== bpi_tester_top.sv ====
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
// Summary of operation
// - generate and lock onto 2E7, 2E11, 2E15 and QRSS sequences
// - repeating user pattern of 1 to 32 bits, sent and checked
// - two alternating 16-bit words, swapping after 1 to 256 words
// - checker holds a 32-bit bit count and 24-bit error count
// - events: sync change, bit error, overflow of either counter
// - each event masked by its own bit in tester_control_one
// - direction bit attaches tester to network or backplane side
// - tx and rx slot selectors map tester into chosen channels
// - in T1, framing bit position usable per direction by enable bits
// - alt words: first in low half, second in high half, repeated by count
// - locked bit counter counts every bit, saturates, sets overflow flag
// - locked error counter counts errored bits, saturates, sets overflow
// - 0 to 1 transition of counter clear bit clears both counters
// - insertion only on transmit path in T1, whole frame or channels
// - last bit of each rate interval inverted, 1 in 16 flips sixteenth
// - framing bits not counted and never corrupted
// - rate change takes effect only at a frame boundary
// - rate field zero inserts nothing even when continuous
// - counted mode starts on 0 to 1 transition of load bit
// - quantity is ten bits up to 1023, zero means none
// - remaining errors readable anytime, decrements per error inserted in counted mode
module bpi_tester_top
   import bpi_pkg::*;
#(
   parameter int BIT_CNT_W = 32,
   parameter int ERR_CNT_W = 24
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire bpi_stream_t tx_i,
   input wire bpi_stream_t rx_i,
   output logic tx_data_o,
   output logic tx_valid_o,
   output logic rx_data_o,
   output logic rx_valid_o,
   output logic sync_o
);

   if (BIT_CNT_W < 2 || BIT_CNT_W > 32 || ERR_CNT_W < 2 || ERR_CNT_W > 32) begin : g_chk
      $error("counter widths must lie between 2 and 32");
   end

   localparam logic [BIT_CNT_W-1:0] BIT_MAX = '1;
   localparam logic [ERR_CNT_W-1:0] ERR_MAX = '1;

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic rs1_r;
   logic rst_n;

   // two-stage release of the async reset
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rs1_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rs1_r <= 1'b1;
         rst_n <= rs1_r;
      end
   end

   // ------------------------------------------------------------
   // register bus
   // ------------------------------------------------------------
   logic wait_r;
   logic [31:0] rdata_r;
   logic [12:0] ctrl1_r;
   logic [4:0] attach_r;
   logic [31:0] txsel_r;
   logic [31:0] rxsel_r;
   logic [31:0] pattern_r;
   logic [7:0] altcnt_r;
   logic [8:0] insctrl_r;
   logic [9:0] qty_r;
   logic [31:0] inssel_r;
   logic [BIT_CNT_W-1:0] bitcnt_r;
   logic [ERR_CNT_W-1:0] errcnt_r;
   logic [9:0] remain_r;
   logic chg_evt_r, err_evt_r, ovf_evt_r, bco_r, eco_r;
   bpi_sync_t state_r;
   wire [7:0] ofs = {avs_address_i[7:2], 2'b00};
   wire wr_fire = avs_write_i && !wait_r;
   wire rd_take = avs_read_i && wait_r;
   wire [5:0] info_word = {ovf_evt_r, eco_r, bco_r, err_evt_r, chg_evt_r,
                           state_r == BPI_LOCK};
   wire [31:0] bitcnt_word = 32'(bitcnt_r);
   wire [31:0] errcnt_word = 32'(errcnt_r);

   // read selection, unmapped offsets read zero
   wire [31:0] rd_data =
      (ofs == OFS_CTRL1) ? {19'h0, ctrl1_r} :
      (ofs == OFS_ATTACH) ? {27'h0, attach_r} :
      (ofs == OFS_TXSEL) ? txsel_r :
      (ofs == OFS_RXSEL) ? rxsel_r :
      (ofs == OFS_PATTERN) ? pattern_r :
      (ofs == OFS_ALTCNT) ? {24'h0, altcnt_r} :
      (ofs == OFS_BITCNT) ? bitcnt_word :
      (ofs == OFS_ERRCNT) ? errcnt_word :
      (ofs == OFS_INFO) ? {26'h0, info_word} :
      (ofs == OFS_INSCTRL) ? {23'h0, insctrl_r} :
      (ofs == OFS_QTY) ? {22'h0, qty_r} :
      (ofs == OFS_INSSEL) ? inssel_r :
      (ofs == OFS_REMAIN) ? {22'h0, remain_r} : 32'h00000000;
   wire [31:0] wr_word = bpi_merge(rd_data, avs_writedata_i, avs_byteenable_i);
   wire info_clr = rd_take && (ofs == OFS_INFO);

   // one wait cycle per access, read data captured with it
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         wait_r <= 1'b1;
         rdata_r <= 32'h00000000;
      end else begin
         wait_r <= !((avs_read_i || avs_write_i) && wait_r);
         if (rd_take) begin
            rdata_r <= rd_data;
         end
      end
   end

   // writable registers
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctrl1_r <= 13'h0000;
         attach_r <= 5'h00;
         txsel_r <= 32'h00000000;
         rxsel_r <= 32'h00000000;
         pattern_r <= PATTERN_RST;
         altcnt_r <= ALTCNT_RST;
         insctrl_r <= 9'h000;
         qty_r <= 10'h000;
         inssel_r <= 32'h00000000;
      end else if (wr_fire) begin
         if (ofs == OFS_CTRL1) ctrl1_r <= wr_word[12:0];
         if (ofs == OFS_ATTACH) attach_r <= wr_word[4:0];
         if (ofs == OFS_TXSEL) txsel_r <= wr_word;
         if (ofs == OFS_RXSEL) rxsel_r <= wr_word;
         if (ofs == OFS_PATTERN) pattern_r <= wr_word;
         if (ofs == OFS_ALTCNT) altcnt_r <= wr_word[7:0];
         if (ofs == OFS_INSCTRL) insctrl_r <= wr_word[8:0];
         if (ofs == OFS_QTY) qty_r <= wr_word[9:0];
         if (ofs == OFS_INSSEL) inssel_r <= wr_word;
      end
   end

   // ------------------------------------------------------------
   // path attachment and pattern generator
   // ------------------------------------------------------------
   bpi_mode_t mode;
   assign mode = bpi_mode_t'(ctrl1_r[C1_MODE +: 3]);
   wire [4:0] len_m1 = ctrl1_r[C1_LEN +: 5];
   wire is_rep = (mode == BPI_REPEAT);
   wire is_pat = is_rep || (mode == BPI_ALTWORD);
   wire t1 = attach_r[AT_T1];
   wire dir_bp = attach_r[AT_DIR];
   wire ena = attach_r[AT_ENA];
   // generator drives tx toward network or rx toward backplane
   bpi_stream_t gen_s, chk_s;
   assign gen_s = dir_bp ? rx_i : tx_i;
   assign chk_s = dir_bp ? tx_i : rx_i;
   wire gen_ok = gen_s.fbit ? (t1 && attach_r[AT_TFU]) : txsel_r[gen_s.slot];
   wire chk_ok = chk_s.fbit ? (t1 && attach_r[AT_RFU]) : rxsel_r[chk_s.slot];
   wire gen_step = ena && gen_s.en && gen_ok;
   wire chk_step = ena && chk_s.en && chk_ok;

   logic [31:0] gen_hist_r;
   bpi_ptr_t gen_ptr_r, ref_ptr_r;
   // pattern bit: low half is first word, high half second
   wire gen_pbit = is_rep ? pattern_r[gen_ptr_r.idx] :
                   pattern_r[{gen_ptr_r.wsel, gen_ptr_r.idx[3:0]}];
   wire gen_bit = is_pat ? gen_pbit : bpi_prbs(gen_hist_r, mode);
   wire bpi_ptr_t gen_ptr_nxt = bpi_step(gen_ptr_r, is_rep, len_m1, altcnt_r);

   // generator history and pattern position
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         gen_hist_r <= SEED_RST;
         gen_ptr_r <= '0;
      end else if (gen_step) begin
         gen_hist_r <= {gen_bit, gen_hist_r[31:1]};
         gen_ptr_r <= gen_ptr_nxt;
      end
   end

   // ------------------------------------------------------------
   // receive checker
   // ------------------------------------------------------------
   logic [31:0] chk_hist_r;
   logic [5:0] good_r;
   logic [5:0] win_r;
   logic [2:0] errs_r;
   wire [31:0] hist_nxt = {chk_s.data, chk_hist_r[31:1]};
   wire ref_bit = pattern_r[{ref_ptr_r.wsel, ref_ptr_r.idx[3:0]}];
   wire rep_bit = chk_hist_r[5'h1F - len_m1];
   wire exp_bit = is_rep ? rep_bit :
                  (mode == BPI_ALTWORD) ? ref_bit : bpi_prbs(chk_hist_r, mode);
   wire bit_err = chk_s.data ^ exp_bit;
   // first word then second word seen: position after one second word
   wire align = (mode == BPI_ALTWORD) && (state_r == BPI_HUNT) && (hist_nxt == pattern_r);
   wire bpi_ptr_t align_ptr = bpi_step('{wsel: 1'b1, cnt: 8'h00, idx: 5'h0F},
                                       1'b0, len_m1, altcnt_r);
   wire bpi_ptr_t ref_ptr_nxt = bpi_step(ref_ptr_r, 1'b0, len_m1, altcnt_r);
   wire locked = (state_r == BPI_LOCK);
   wire go_lock = !locked && !bit_err && (good_r == LOCK_GOOD_M1);
   wire go_hunt = locked && bit_err && (errs_r == LOSE_ERRS_M1);
   wire sync_chg = chk_step && (go_lock || go_hunt);

   // synchroniser: lock on 32 good bits, lose on 6 errors in 64
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= BPI_HUNT;
         chk_hist_r <= 32'h00000000;
         ref_ptr_r <= '0;
         good_r <= 6'h00;
         win_r <= 6'h00;
         errs_r <= 3'h0;
      end else if (chk_step) begin
         // once locked the history runs on expected bits, so one bad bit counts once
         chk_hist_r <= locked ? {exp_bit, chk_hist_r[31:1]} : hist_nxt;
         ref_ptr_r <= align ? align_ptr : ref_ptr_nxt;
         good_r <= bit_err ? 6'h00 : good_r + 6'h01;
         win_r <= locked ? win_r + 6'h01 : 6'h00;
         errs_r <= (!locked || go_hunt || win_r == 6'h3F) ? 3'h0 : errs_r + {2'h0, bit_err};
         unique case (state_r)
            BPI_HUNT: if (go_lock) state_r <= BPI_LOCK;
            BPI_LOCK: if (go_hunt) state_r <= BPI_HUNT;
         endcase
      end
   end

   // ------------------------------------------------------------
   // bit and error counters, event flags
   // ------------------------------------------------------------
   logic clr_prev_r;
   wire clr_pulse = ctrl1_r[C1_CLR] && !clr_prev_r;
   wire cnt_bit = chk_step && locked;
   wire cnt_err = cnt_bit && bit_err;
   wire bco_set = cnt_bit && (bitcnt_r == BIT_MAX - 1'b1);
   wire eco_set = cnt_err && (errcnt_r == ERR_MAX - 1'b1);
   wire chg_set = sync_chg && !ctrl1_r[C1_MSK_CHG];
   wire err_set = cnt_err && !ctrl1_r[C1_MSK_ERR];
   wire ovf_set = (bco_set || eco_set) && !ctrl1_r[C1_MSK_OVF];

   // counters saturate at all ones
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         clr_prev_r <= 1'b0;
         bitcnt_r <= '0;
         errcnt_r <= '0;
         bco_r <= 1'b0;
         eco_r <= 1'b0;
      end else begin
         clr_prev_r <= ctrl1_r[C1_CLR];
         if (clr_pulse) begin
            bitcnt_r <= '0;
            errcnt_r <= '0;
            bco_r <= 1'b0;
            eco_r <= 1'b0;
         end else begin
            if (cnt_bit && bitcnt_r != BIT_MAX) bitcnt_r <= bitcnt_r + 1'b1;
            if (cnt_err && errcnt_r != ERR_MAX) errcnt_r <= errcnt_r + 1'b1;
            if (bco_set) bco_r <= 1'b1;
            if (eco_set) eco_r <= 1'b1;
         end
      end
   end

   // latched events, read clears, a new event wins
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         chg_evt_r <= 1'b0;
         err_evt_r <= 1'b0;
         ovf_evt_r <= 1'b0;
      end else begin
         chg_evt_r <= (chg_evt_r && !info_clr) || chg_set;
         err_evt_r <= (err_evt_r && !info_clr) || err_set;
         ovf_evt_r <= (ovf_evt_r && !info_clr) || ovf_set;
      end
   end

   // ------------------------------------------------------------
   // payload error inserter
   // ------------------------------------------------------------
   logic [3:0] rate_r;
   logic [INS_CNT_W-1:0] icnt_r;
   logic load_prev_r;
   wire load_pulse = insctrl_r[IC_LOAD] && !load_prev_r;
   wire cont = insctrl_r[IC_CONT];
   wire [4:0] rate_sh = {1'b0, rate_r} + RATE_SHIFT;
   wire [INS_CNT_W-1:0] icnt_last = (INS_CNT_W'(1) << rate_sh) - INS_CNT_W'(1);
   wire ins_chan = !insctrl_r[IC_CHSEL] || inssel_r[tx_i.slot];
   wire ins_count = tx_i.en && t1 && !tx_i.fbit && ins_chan && (rate_r != 4'h0);
   wire ins_flip = ins_count && (icnt_r == icnt_last) && (cont || remain_r != 10'h000);

   // rate follows the field only at the first bit of a frame
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rate_r <= 4'h0;
         icnt_r <= '0;
         load_prev_r <= 1'b0;
         remain_r <= 10'h000;
      end else begin
         load_prev_r <= insctrl_r[IC_LOAD];
         if (tx_i.en && tx_i.frame) rate_r <= insctrl_r[IC_RATE +: 4];
         if (ins_count) icnt_r <= (icnt_r == icnt_last) ? '0 : icnt_r + 1'b1;
         if (load_pulse) begin
            remain_r <= qty_r;
         end else if (ins_flip && !cont) begin
            remain_r <= remain_r - 10'h001;
         end
      end
   end

   // ------------------------------------------------------------
   // data path outputs
   // ------------------------------------------------------------
   wire tx_base = (!dir_bp && gen_step) ? gen_bit : tx_i.data;
   wire rx_base = (dir_bp && gen_step) ? gen_bit : rx_i.data;

   // registered streams, inserter acts on transmit only
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         tx_data_o <= 1'b0;
         tx_valid_o <= 1'b0;
         rx_data_o <= 1'b0;
         rx_valid_o <= 1'b0;
         sync_o <= 1'b0;
      end else begin
         tx_valid_o <= tx_i.en;
         rx_valid_o <= rx_i.en;
         sync_o <= (state_r == BPI_LOCK);
         if (tx_i.en) tx_data_o <= tx_base ^ ins_flip;
         if (rx_i.en) rx_data_o <= rx_base;
      end
   end

   assign avs_readdata_o = rdata_r;
   assign avs_waitrequest_o = wait_r;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   bitcnt_sat_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      bitcnt_r == BIT_MAX && !clr_pulse |=> bitcnt_r == BIT_MAX && bco_r)
      else $error("bit counter left saturation");
   errcnt_inc_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      cnt_err && errcnt_r != ERR_MAX && !clr_pulse |=> errcnt_r == $past(errcnt_r) + 1'b1)
      else $error("error counter missed an errored bit");
   cnt_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      clr_pulse |=> bitcnt_r == '0 && errcnt_r == '0 && !bco_r && !eco_r)
      else $error("counter clear did not clear");
   fbit_kept_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      tx_i.en && tx_i.fbit |-> !ins_flip)
      else $error("framing bit corrupted");
   rate_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      rate_r == 4'h0 || !t1 |-> !ins_flip)
      else $error("error inserted with zero rate or outside T1");
   rate_frame_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      !(tx_i.en && tx_i.frame) |=> rate_r == $past(rate_r))
      else $error("rate changed away from frame boundary");
   load_start_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      load_pulse |=> remain_r == $past(qty_r))
      else $error("quantity not loaded on load edge");
   remain_dec_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      ins_flip && !cont && !load_pulse |=> remain_r == $past(remain_r) - 10'h001
      && tx_data_o == !$past(tx_base))
      else $error("remaining count or inverted bit wrong");
   sync_event_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      chg_set |=> chg_evt_r ##1 sync_o == locked)
      else $error("sync change not latched");
   ovf_event_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      (bco_set || eco_set) && ctrl1_r[C1_MSK_OVF] && !ovf_evt_r |=> !ovf_evt_r)
      else $error("masked overflow was latched");

endmodule

// ==== bpi_pkg.sv ====
package bpi_pkg;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL1 = 8'h00;   // tester_control_one
   localparam logic [7:0] OFS_ATTACH = 8'h04;  // tester_attach_control
   localparam logic [7:0] OFS_TXSEL = 8'h08;   // tx_slot_select
   localparam logic [7:0] OFS_RXSEL = 8'h0C;   // rx_slot_select
   localparam logic [7:0] OFS_PATTERN = 8'h10; // pattern_word_byte0 and up
   localparam logic [7:0] OFS_ALTCNT = 8'h14;  // alt_word_repeat_count
   localparam logic [7:0] OFS_BITCNT = 8'h18;  // bit_count_byte0 and up
   localparam logic [7:0] OFS_ERRCNT = 8'h1C;  // error_count_byte0 and up
   localparam logic [7:0] OFS_INFO = 8'h20;    // tester_event_info
   localparam logic [7:0] OFS_INSCTRL = 8'h24; // insert_rate_control
   localparam logic [7:0] OFS_QTY = 8'h28;     // error_quantity
   localparam logic [7:0] OFS_INSSEL = 8'h2C;  // insertion channel select
   localparam logic [7:0] OFS_REMAIN = 8'h30;  // errors_remaining

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int C1_CLR = 0;      // counter_clear_toggle
   localparam int C1_MSK_CHG = 1;  // mask sync change event
   localparam int C1_MSK_ERR = 2;  // mask bit error event
   localparam int C1_MSK_OVF = 3;  // mask overflow event
   localparam int C1_MODE = 4;     // 3-bit pattern mode
   localparam int C1_LEN = 8;      // 5-bit repeat length minus one
   localparam int AT_ENA = 0;
   localparam int AT_DIR = 1;      // 0 network, 1 backplane
   localparam int AT_RFU = 2;      // rx_framing_bit_use
   localparam int AT_TFU = 3;      // tx_framing_bit_use
   localparam int AT_T1 = 4;
   localparam int IN_SYNC = 0;
   localparam int IN_CHG = 1;
   localparam int IN_ERR = 2;
   localparam int IN_BCO = 3;      // bit_count_overflow
   localparam int IN_ECO = 4;      // error_count_overflow
   localparam int IN_OVF = 5;
   localparam int IC_RATE = 0;     // 4-bit insert_rate_field
   localparam int IC_CONT = 4;
   localparam int IC_LOAD = 7;     // load_error_quantity
   localparam int IC_CHSEL = 8;

   // ------------------------------------------------------------
   // reset values and counts
   // ------------------------------------------------------------
   localparam logic [31:0] PATTERN_RST = 32'hFFFFFFFF;
   localparam logic [31:0] SEED_RST = 32'hFFFFFFFF;
   localparam logic [7:0] ALTCNT_RST = 8'h01;
   localparam logic [5:0] LOCK_GOOD_M1 = 6'h1F;  // 32 good bits to lock
   localparam logic [2:0] LOSE_ERRS_M1 = 3'h5;   // 6 errors per window
   localparam logic [4:0] RATE_SHIFT = 5'h03;    // rate 1 is 1 in 16
   localparam int INS_CNT_W = 19;

   typedef enum logic [2:0] {
      BPI_PRBS7, BPI_PRBS11, BPI_PRBS15, BPI_QRSS, BPI_REPEAT, BPI_ALTWORD
   } bpi_mode_t;

   typedef enum logic {BPI_HUNT, BPI_LOCK} bpi_sync_t;

   // one bit position of a serial stream
   typedef struct packed {
      logic en;          // bit strobe
      logic data;
      logic fbit;        // framing bit position
      logic frame;       // first bit of a frame
      logic [4:0] slot;  // channel number
   } bpi_stream_t;

   // position inside a repeating or alternating pattern
   typedef struct packed {
      logic wsel;
      logic [7:0] cnt;
      logic [4:0] idx;
   } bpi_ptr_t;

   // ------------------------------------------------------------
   // shared decoders
   // ------------------------------------------------------------
   // next pseudorandom bit from history, newest bit at [31]
   function automatic logic bpi_prbs(input logic [31:0] h, input bpi_mode_t m);
      logic b;
      b = 1'b0;
      unique case (m)
         BPI_PRBS7: b = h[26] ^ h[25];
         BPI_PRBS11: b = h[23] ^ h[21];
         BPI_PRBS15: b = h[18] ^ h[17];
         BPI_QRSS: b = h[15] ^ h[12];
         default: b = 1'b0;
      endcase
      return b;
   endfunction

   // advance a pattern position by one bit
   function automatic bpi_ptr_t bpi_step(input bpi_ptr_t p, input logic rep,
                                         input logic [4:0] len_m1,
                                         input logic [7:0] words);
      bpi_ptr_t n;
      n = p;
      if (rep) begin
         n.idx = (p.idx == len_m1) ? 5'h00 : p.idx + 5'h01;
      end else if (p.idx[3:0] == 4'hF) begin
         n.idx = 5'h00;
         if (p.cnt + 8'h01 == words) begin
            n.cnt = 8'h00;
            n.wsel = ~p.wsel;
         end else begin
            n.cnt = p.cnt + 8'h01;
         end
      end else begin
         n.idx = p.idx + 5'h01;
      end
      return n;
   endfunction

   // write data merged under byte enables
   function automatic logic [31:0] bpi_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

endpackage

// ==== bpi_framer_model.sv ====
`timescale 1ns/1ns
// T1 framer stand-in: 193-bit frames, a strobe every other clock,
// received stream looped back from the tester's transmit output
module bpi_framer_model
   import bpi_pkg::*;
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic tx_data_i,
   input wire logic tx_valid_i,
   output bpi_stream_t tx_o,
   output bpi_stream_t rx_o
);
   logic ph_r;
   logic [7:0] pos_r;
   bpi_stream_t meta_r;
   // ------------------------------------------------------------
   // stream shape
   // ------------------------------------------------------------
   // framing bit at position 0, then 24 channels of 8 bits
   assign tx_o = '{en: ph_r, data: pos_r[0] ^ pos_r[3], fbit: pos_r == 8'h00,
                   frame: pos_r == 8'h00, slot: 5'((pos_r - 8'h01) >> 3)};
   // loopback; between strobes the line shows the inverse value
   assign rx_o = '{en: tx_valid_i, data: tx_valid_i ? tx_data_i : ~tx_data_i,
                   fbit: meta_r.fbit, frame: meta_r.frame, slot: meta_r.slot};
   // bit position and copy of the position that produced the output bit
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ph_r <= 1'b0;
         pos_r <= 8'h00;
         meta_r <= '0;
      end else begin
         ph_r <= ~ph_r;
         if (ph_r) begin
            pos_r <= (pos_r == 8'd192) ? 8'h00 : pos_r + 8'h01;
            meta_r <= tx_o;
         end
      end
   end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ns
module tb_top
   import bpi_pkg::*;
;
   logic clk_i = 1'b0, rstn_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
   logic [7:0] avs_address_i = 8'h00;
   logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q, b1;
   logic [3:0] avs_byteenable_i = 4'hF;
   logic avs_waitrequest_o, tx_data_o, tx_valid_o, rx_data_o, rx_valid_o, sync_o;
   bpi_stream_t tx_s, rx_s;
   int err_count = 0, compares = 0, cyc = 0, nbits = 0, snap = 0;
   bpi_tester_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .tx_i(tx_s), .rx_i(rx_s), .tx_data_o(tx_data_o),
      .tx_valid_o(tx_valid_o), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .sync_o(sync_o));
   bpi_framer_model far (.clk_i(clk_i), .rstn_i(rstn_i), .tx_data_i(tx_data_o),
      .tx_valid_i(tx_valid_o), .tx_o(tx_s), .rx_o(rx_s));
   // ------------------------------------------------------------
   // clock, timeout and bus tasks
   // ------------------------------------------------------------
   initial begin
      forever #2 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         tally_and_finish();
      end
   end
   // payload bits offered to the checker, counted from the far side
   always @(posedge clk_i) begin
      if (rx_s.en && !rx_s.fbit) nbits <= nbits + 1;
   end
   // one access, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      avs_address_i <= a;
      avs_write_i <= w;
      avs_read_i <= ~w;
      avs_writedata_i <= d;
      do begin
         @(posedge clk_i);
         if (avs_waitrequest_o === 1'b1) snap = nbits;
      end while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task automatic tally_and_finish();
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rdchk(OFS_PATTERN, 32'hFFFFFFFF);
      rdchk(OFS_ALTCNT, 32'h00000001);
      bus(1'b1, 8'h3C, 32'hFFFFFFFF);
      rdchk(8'h3C, 32'h00000000);
      bus(1'b1, OFS_PATTERN, 32'h5AD6B5AD);
      bus(1'b1, OFS_CTRL1, 32'h00000440);
      bus(1'b1, OFS_TXSEL, 32'hFFFFFFFF);
      bus(1'b1, OFS_RXSEL, 32'hFFFFFFFF);
      bus(1'b1, OFS_ATTACH, 32'h00000011);
      repeat (600) @(posedge clk_i);
      chk({31'h0, sync_o}, 32'h1);
      rdchk(OFS_INFO, 32'h00000003);
      rdchk(OFS_ERRCNT, 32'h0);
      bus(1'b0, OFS_BITCNT, 32'h0);
      b1 = q - 32'(snap);
      bus(1'b0, OFS_BITCNT, 32'h0);
      chk(q - b1, 32'(snap));
      bus(1'b1, OFS_QTY, 32'h00000002);
      bus(1'b1, OFS_INSCTRL, 32'h00000081);
      rdchk(OFS_REMAIN, 32'h2);
      repeat (2000) @(posedge clk_i);
      rdchk(OFS_REMAIN, 32'h0);
      rdchk(OFS_ERRCNT, 32'h2);
      bus(1'b0, OFS_INFO, 32'h0);
      chk(q & 32'h4, 32'h4);
      rdchk(OFS_INFO, 32'h00000001);
      bus(1'b1, OFS_INSCTRL, 32'h00000000);
      repeat (500) @(posedge clk_i);
      bus(1'b1, OFS_INSCTRL, 32'h00000010);
      repeat (1500) @(posedge clk_i);
      rdchk(OFS_ERRCNT, 32'h2);
      bus(1'b1, OFS_CTRL1, 32'h00000441);
      rdchk(OFS_ERRCNT, 32'h0);
      // every pattern mode in turn must regain lock
      for (int m = 0; m < 6; m++) begin
         bus(1'b1, OFS_CTRL1, 32'(m) << 4);
         repeat (800) @(posedge clk_i);
         chk({31'h0, sync_o}, 32'h1);
      end
      tally_and_finish();
   end
endmodule
